//--- bench/output_voltage_limit_commands_tb.sv
`timescale 1ns/1ps
module output_voltage_limit_commands_tb import vreg_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err_q;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, st_q, rd_q;
	logic [15:0] vin = 16'h0200, vs = 16'h1000, pk = 16'h1000, app;
	logic adc = 0, ovc = 0, uvc = 0, ramp = 0, act = 0, tick = 0, pwm = 1, conv, hsg, lsg, fpn;
	int miscompares = 0, checked = 0, cyc = 0;
	time t_ov = 0, t_sp = 0;
	logic [7:0] rc [12] = '{CODE_FORMAT, CODE_SETPOINT, CODE_UPPER_CLAMP, CODE_MARGIN_HIGH, CODE_MARGIN_LOW,
		CODE_OV_FAULT, CODE_OV_WARN, CODE_UV_WARN, CODE_UV_FAULT, CODE_OK_RISE, CODE_OK_FALL, CODE_CEILING};
	logic [15:0] rv [12] = '{16'(RST_FORMAT), RST_SETPOINT, RST_UPPER_CLAMP, RST_MARGIN_HIGH, RST_MARGIN_LOW,
		RST_OV_FAULT, RST_OV_WARN, RST_UV_WARN, RST_UV_FAULT, RST_OK_RISE, RST_OK_FALL, RST_CEILING};
	always #2.5 pclk = ~pclk;
	cmd_link_if link();
	vreg_device #(.RECALC_CYCLES(40)) u_vreg_device (.pclk(pclk), .presetn(presetn), .link(link),
		.vin_measured(vin), .adc_valid(adc), .vout_sample(vs), .output_peak_record(pk), .ov_comparator(ovc),
		.uv_comparator(uvc), .ramp_active(ramp), .output_active(act), .slew_tick(tick), .pwm_high(pwm),
		.conversion_enable(conv), .high_side_gate(hsg), .low_side_gate_bit(lsg), .fault_pin_n(fpn),
		.applied_setpoint(app));
	vreg_host #(.GUARD_CYCLES(40)) u_vreg_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link));
	vreg_link_props u_vreg_link_props (.pclk(pclk), .presetn(presetn), .req_valid(link.req_valid),
		.req_write(link.req_write), .req_code(link.req_code), .req_wdata(link.req_wdata),
		.rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err), .rsp_rdata(link.rsp_rdata),
		.alert_n(link.alert_n), .regulation_ok_signal(link.regulation_ok_signal));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// the wait ends on pready; only the cycle ceiling ends one that hangs
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// one link command through the host: code, data, go; then poll until idle
	task automatic link_op(input logic wr, input logic [7:0] c, input logic [15:0] d, input logic nf = 0);
		logic [31:0] q;
		apb(1, APB_CODE, {24'h00_0000, c}, q);
		apb(1, APB_WDATA, {16'h0000, d}, q);
		apb(1, APB_CTRL, {29'h0000_0000, nf, wr, 1'b1}, q);
		do begin
			apb(0, APB_STATUS, 32'h0000_0000, st_q);
		end while (st_q[0] !== 1'b0);
		apb(0, APB_RDATA, 32'h0000_0000, rd_q);
	endtask
	task automatic tk(input int n);
		repeat (n) begin
			tick <= 1;
			@(posedge pclk);
			tick <= 0;
			@(posedge pclk);
		end
	endtask
	task automatic adc_pulse(input logic [15:0] s, input logic [15:0] p);
		vs <= s;
		pk <= p;
		adc <= 1;
		@(posedge pclk);
		adc <= 0;
		repeat (2) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (link.req_valid && link.req_code == CODE_OV_FAULT)
			t_ov = $time;
		if (link.req_valid && link.req_code == CODE_SETPOINT)
			t_sp = $time;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) begin
			link_op(0, rc[i], 16'h0000);
			chk("reset value", rd_q, {16'h0000, rv[i]});
		end
		link_op(0, CODE_COMMON, 16'h0000);
		chk("idle bits", rd_q[6:5], 2'b11);
		apb(0, 8'h40, 32'h0000_0000, rd_q);
		chk("unmapped", err_q, 1'b1);
		for (int i = 0; i < 2; i++) begin
			link_op(1, i ? CODE_CEILING : CODE_FORMAT, 16'h0000);
			chk("ro refused", st_q[2], 1'b1);
		end
		link_op(1, CODE_SETPOINT, 16'h6000);
		link_op(0, CODE_SETPOINT, 16'h0000);
		chk("clamped", rd_q, 32'h0000_5800);
		link_op(0, CODE_STATUS_OUT, 16'h0000);
		chk("max warn", rd_q[SO_MAX_WARN_BIT], 1'b1);
		link_op(0, CODE_STATUS_WORD, 16'h0000);
		chk("logic fault", rd_q[SW_LOGIC_BIT], 1'b1);
		link_op(1, CODE_SETPOINT, 16'h1000);
		link_op(1, CODE_FILTER_RES, 16'h1234, 1);
		link_op(0, CODE_FILTER_RES, 16'h0000);
		chk("filter zero", rd_q, 32'h0000_0000);
		link_op(1, CODE_INPUT_STOP, 16'h0200);
		chk("stop at level", conv, 1'b0);
		vin <= 16'h0201;
		repeat (3) @(posedge pclk);
		chk("run above", conv, 1'b1);
		ovc <= 1;
		repeat (2) @(posedge pclk);
		chk("high gate off", {hsg, lsg}, 2'b01);
		ovc <= 0;
		repeat (2) @(posedge pclk);
		chk("gates free", {hsg, lsg, fpn}, 3'b101);
		link_op(1, CODE_OV_RESPONSE, 16'h0000);
		chk("no pin at zero", fpn, 1'b1);
		// earlier refused writes and the first fault are sticky; start clean
		link_op(1, CODE_CLEAR_STATUS, 16'h0000);
		link_op(1, CODE_OV_RESPONSE, 16'h0040);
		chk("no pin before fault", fpn, 1'b1);
		ovc <= 1;
		repeat (2) @(posedge pclk);
		ovc <= 0;
		repeat (2) @(posedge pclk);
		chk("pin other", fpn, 1'b0);
		adc_pulse(16'h1200, 16'h1000);
		chk("sample ignored", link.alert_n, 1'b1);
		adc_pulse(16'h1000, 16'h1200);
		chk("ov alert", link.alert_n, 1'b0);
		link_op(0, CODE_STATUS_OUT, 16'h0000);
		chk("ov warn", rd_q[SO_OV_WARN_BIT], 1'b1);
		link_op(0, CODE_STATUS_WORD, 16'h0000);
		chk("summary", {rd_q[SW_OUT_BIT], rd_q[SW_OTHER_BIT]}, 2'b11);
		link_op(1, CODE_CLEAR_STATUS, 16'h0000);
		chk("cleared", link.alert_n, 1'b1);
		adc_pulse(16'h0e00, 16'h0e00);
		link_op(0, CODE_STATUS_OUT, 16'h0000);
		chk("uv warn", {rd_q[SO_UV_WARN_BIT], link.alert_n}, 2'b10);
		link_op(1, CODE_STATUS_WORD, 16'h0000);
		link_op(0, CODE_STATUS_WORD, 16'h0000);
		chk("uv summary", {rd_q[SW_OUT_BIT], rd_q[SW_OTHER_BIT]}, 2'b11);
		link_op(1, CODE_OK_RISE, 16'h2000);
		link_op(1, CODE_OK_FALL, 16'h0100);
		chk("ok level", link.regulation_ok_signal, 1'b1);
		uvc <= 1;
		repeat (2) @(posedge pclk);
		chk("ok comparator", link.regulation_ok_signal, 1'b0);
		uvc <= 0;
		act <= 1;
		link_op(1, CODE_MARGIN_HIGH, 16'h1010);
		link_op(1, CODE_OPERATION, 16'h0020);
		tk(1);
		chk("one step", app, 16'h1001);
		tk(20);
		chk("margin high", app, 16'h1010);
		link_op(1, CODE_MARGIN_LOW, 16'h0ff8);
		link_op(1, CODE_OPERATION, 16'h0010);
		tk(30);
		chk("margin low", app, 16'h0ff8);
		link_op(1, CODE_UPPER_CLAMP, 16'h1004);
		link_op(1, CODE_OPERATION, 16'h0020);
		tk(20);
		chk("upper clamp", app, 16'h1004);
		link_op(1, CODE_UPPER_CLAMP, 16'h5800);
		link_op(1, CODE_OPERATION, 16'h0000);
		tk(10);
		link_op(1, CODE_OV_FAULT, 16'h1200);
		link_op(0, CODE_COMMON, 16'h0000);
		chk("busy bits", rd_q[6:5] != 2'b11, 1'b1);
		ramp <= 1;
		link_op(1, CODE_SETPOINT, 16'h1008);
		// guard of 40 cycles at 5 ns must pass before the setpoint goes out
		chk("guard gap", (t_sp - t_ov) >= 40 * 5, 1'b1);
		tk(10);
		chk("ramp hold", app, 16'h1000);
		ramp <= 0;
		tk(10);
		chk("nominal", app, 16'h1008);
		repeat (60) @(posedge pclk);
		link_op(0, CODE_COMMON, 16'h0000);
		chk("idle again", rd_q[6:5], 2'b11);
		tally_and_finish();
	end
endmodule // output_voltage_limit_commands_tb

//--- bench/vreg_link_props.sv
`timescale 1ns/1ps
module vreg_link_props import vreg_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// command link
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_code,
	input wire logic [15:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [15:0] rsp_rdata,
	input wire logic alert_n,
	input wire logic regulation_ok_signal
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] setpoint_ff;
	logic [15:0] nxt_setpoint;
	wire wr_req = req_valid && req_write;
	wire rd_req = req_valid && !req_write;
	wire ro_code = req_code inside {CODE_FORMAT, CODE_CEILING, CODE_STATUS_WORD, CODE_STATUS_OUT,
		CODE_STATUS_LOGIC, CODE_COMMON};
	// expected setpoint after the fixed-ceiling clamp
	assign nxt_setpoint = (wr_req && req_code == CODE_SETPOINT) ?
		((req_wdata > RST_CEILING) ? RST_CEILING : req_wdata) : setpoint_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			setpoint_ff <= RST_SETPOINT;
		else
			setpoint_ff <= nxt_setpoint;
	end
	////////////////////////////////////////////////////////////////
	a_answer_next_cycle: assert property (req_valid |=> rsp_valid)
		else $error("link request got no answer");
	a_answer_has_cause: assert property (rsp_valid |-> $past(req_valid))
		else $error("answer without request");
	a_answer_one_cycle: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	a_ro_write_refused: assert property (wr_req && ro_code |=> rsp_valid && rsp_err)
		else $error("write to read-only code accepted");
	a_format_fixed: assert property (rd_req && req_code == CODE_FORMAT |=> rsp_rdata == {8'h00, RST_FORMAT})
		else $error("format byte wrong");
	a_ceiling_fixed: assert property (rd_req && req_code == CODE_CEILING |=> rsp_rdata == RST_CEILING)
		else $error("ceiling readback wrong");
	a_setpoint_clamped: assert property (rd_req && req_code == CODE_SETPOINT |=> rsp_rdata == setpoint_ff)
		else $error("setpoint readback wrong");
	a_alert_holds: assert property (!alert_n && !(wr_req && req_code == CODE_CLEAR_STATUS) |=> !alert_n)
		else $error("alert released without clear");
	cover property (wr_req && req_code == CODE_SETPOINT && req_wdata > RST_CEILING);
	cover property (rsp_valid && rsp_err);
	cover property ($fell(alert_n));
	cover property (!regulation_ok_signal);
endmodule // vreg_link_props

//--- rtl/cmd_link_if.sv
`timescale 1ns/1ps
interface cmd_link_if;
	logic req_valid;
	logic req_write;
	logic [7:0] req_code;
	logic [15:0] req_wdata;
	logic rsp_valid;
	logic rsp_err;
	logic [15:0] rsp_rdata;
	logic alert_n;
	logic regulation_ok_signal;
	modport dev (input req_valid, req_write, req_code, req_wdata,
		output rsp_valid, rsp_err, rsp_rdata, alert_n, regulation_ok_signal);
	modport host (output req_valid, req_write, req_code, req_wdata,
		input rsp_valid, rsp_err, rsp_rdata, alert_n, regulation_ok_signal);
endinterface

//--- rtl/vreg_device.sv
`timescale 1ns/1ps
// Function
// [RQ1] stop conversion at programmed input threshold
// [RQ2] host zeroes filter resistance without filter
// [RQ3] read-only format byte, linear, 0x14
// [RQ4] commanded voltage never exceeds upper clamp
// [RQ5] host waits after fault limit change
// [RQ6] common bits 5,6 low while recalculating
// [RQ7] crowbar or zero response: no fault pin
// [RQ8] overvoltage: high gate off, low gate on
// [RQ9] peak record compared with warn limit
// [RQ10] overvoltage warning sets status and alert
// [RQ11] undervoltage warning sets status and alert
// [RQ12] warnings follow adc sample timing
// [RQ13] margin high selected regulates to it
// [RQ14] margin low selected regulates to it
// [RQ15] no setpoint change applied during ramps
// [RQ16] steady output slews at transition rate
// [RQ17] regulation ok follows comparators only
// [RQ18] setpoint reset 0x1000
// [RQ19] overvoltage limits reset 0x119A, 0x1133
// [RQ20] undervoltage limits reset 0x0E66, 0x0ECD
// [RQ21] regulation ok levels reset 0x0EE1, 0x0EB8
// [RQ22] read-only ceiling reads 0x5800
// [RQ23] setpoint above ceiling: clamp, logic fault
// [RQ24] values are mantissa times format exponent
module vreg_device import vreg_pkg::*; #(
	parameter int unsigned RECALC_CYCLES = RECALC_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// command link
	cmd_link_if.dev link,
	// converter measurements
	input wire logic [15:0] vin_measured,
	input wire logic adc_valid,
	input wire logic [15:0] vout_sample,
	input wire logic [15:0] output_peak_record,
	input wire logic ov_comparator,
	input wire logic uv_comparator,
	// sequencing state
	input wire logic ramp_active,
	input wire logic output_active,
	input wire logic slew_tick,
	input wire logic pwm_high,
	// converter controls
	output logic conversion_enable,
	output logic high_side_gate,
	output logic low_side_gate_bit,
	output logic fault_pin_n,
	output logic [15:0] applied_setpoint
);
	logic [15:0] setpoint_ff, clamp_ff, mhigh_ff, mlow_ff, slew_ff, stop_ff, filt_ff;
	logic [15:0] ovf_ff, ovw_ff, uvw_ff, uvf_ff, okr_ff, okf_ff;
	logic [7:0] op_ff, ovresp_ff;
	logic ov_warn_ff, uv_warn_ff, max_warn_ff, cml_ff, ov_fault_ff;
	logic [31:0] busy_cnt_ff;
	logic [15:0] applied_ff;
	logic conv_ff;
	logic rsp_valid_ff, rsp_err_ff;
	logic [15:0] rsp_data_ff;

	////////////////////////////////////////////////////////////////////////////
	wire wr = link.req_valid & link.req_write;
	wire rd = link.req_valid & ~link.req_write;
	wire [7:0] code = link.req_code;
	wire [15:0] wd = link.req_wdata;
	wire clr = wr & (code == CODE_CLEAR_STATUS);
	wire sp_over = wd > RST_CEILING; // [RQ23]
	wire busy = busy_cnt_ff != 32'h0000_0000;
	wire ov_warn_evt = adc_valid & (output_peak_record > ovw_ff); // [RQ9] [RQ12]
	wire uv_warn_evt = adc_valid & (vout_sample < uvw_ff); // [RQ11] [RQ12]
	wire max_evt = wr & (code == CODE_SETPOINT) & sp_over;
	wire any_status = ov_warn_evt | uv_warn_evt | ov_warn_ff | uv_warn_ff | max_warn_ff | cml_ff;
	wire [1:0] margin_sel = op_ff[OP_MARGIN_LSB +: 2];
	wire [15:0] sel_target = (margin_sel == OP_MARGIN_HIGH) ? mhigh_ff : // [RQ13]
		(margin_sel == OP_MARGIN_LOW) ? mlow_ff : setpoint_ff; // [RQ14]
	wire [15:0] target = (sel_target > clamp_ff) ? clamp_ff : sel_target; // [RQ4]
	wire can_slew = output_active & ~ramp_active & slew_tick; // [RQ15]
	wire [16:0] up_sum = {1'b0, applied_ff} + {1'b0, slew_ff};
	wire [15:0] step_up = (up_sum[15:0] > target || up_sum[16]) ? target : up_sum[15:0];
	// widened so a large step near the top of the range cannot wrap
	wire [16:0] dn_floor = {1'b0, target} + {1'b0, slew_ff};
	wire [15:0] step_dn = ({1'b0, applied_ff} < dn_floor) ? target : applied_ff - slew_ff;
	wire [15:0] nxt_applied = !can_slew ? applied_ff :
		(applied_ff < target) ? step_up : (applied_ff > target) ? step_dn : applied_ff; // [RQ16]
	wire crowbar_resp = (ovresp_ff == OV_RESP_CROWBAR) | (ovresp_ff == OV_RESP_NONE);
	// status images; values are mantissas under the format exponent
	// widen single bits before shifting; inverting after widening would fill the upper bits
	wire idle = ~busy;
	wire [15:0] st_out = (16'(ov_warn_ff) << SO_OV_WARN_BIT) | (16'(uv_warn_ff) << SO_UV_WARN_BIT)
		| (16'(max_warn_ff) << SO_MAX_WARN_BIT); // [RQ24]
	wire [15:0] st_logic = 16'(cml_ff) << SL_INVALID_BIT;
	wire st_vout = ov_warn_ff | uv_warn_ff | max_warn_ff;
	wire [15:0] st_word = (16'(st_vout) << SW_OUT_BIT) | (16'(cml_ff) << SW_LOGIC_BIT)
		| (16'(ov_warn_ff | uv_warn_ff) << SW_OTHER_BIT); // [RQ10] [RQ11]
	wire [15:0] st_common = (16'(idle) << CM_IDLE_A_BIT) | (16'(idle) << CM_IDLE_B_BIT); // [RQ6]
	logic [15:0] rd_mux;
	logic rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		case (code)
			CODE_OPERATION: rd_mux = {8'h00, op_ff};
			CODE_FORMAT: rd_mux = {8'h00, RST_FORMAT}; // [RQ3]
			CODE_SETPOINT: rd_mux = setpoint_ff;
			CODE_UPPER_CLAMP: rd_mux = clamp_ff;
			CODE_MARGIN_HIGH: rd_mux = mhigh_ff;
			CODE_MARGIN_LOW: rd_mux = mlow_ff;
			CODE_SLEW_STEP: rd_mux = slew_ff;
			CODE_INPUT_STOP: rd_mux = stop_ff;
			CODE_OV_FAULT: rd_mux = ovf_ff;
			CODE_OV_RESPONSE: rd_mux = {8'h00, ovresp_ff};
			CODE_OV_WARN: rd_mux = ovw_ff;
			CODE_UV_WARN: rd_mux = uvw_ff;
			CODE_UV_FAULT: rd_mux = uvf_ff;
			CODE_OK_RISE: rd_mux = okr_ff;
			CODE_OK_FALL: rd_mux = okf_ff;
			CODE_STATUS_WORD: rd_mux = st_word;
			CODE_STATUS_OUT: rd_mux = st_out;
			CODE_STATUS_LOGIC: rd_mux = st_logic;
			CODE_CEILING: rd_mux = RST_CEILING; // [RQ22]
			CODE_COMMON: rd_mux = st_common;
			CODE_FILTER_RES: rd_mux = filt_ff;
			default: begin
				rd_mux = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// writes to read-only or unknown codes are refused with an error answer
	wire wr_ro = (code == CODE_FORMAT) | (code == CODE_CEILING) | (code == CODE_STATUS_WORD)
		| (code == CODE_STATUS_OUT) | (code == CODE_STATUS_LOGIC) | (code == CODE_COMMON);
	wire wr_err = wr & (~rd_hit | wr_ro) & ~clr;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ff <= 8'h00;
			setpoint_ff <= RST_SETPOINT; // [RQ18]
			clamp_ff <= RST_UPPER_CLAMP;
			mhigh_ff <= RST_MARGIN_HIGH;
			mlow_ff <= RST_MARGIN_LOW;
			slew_ff <= RST_SLEW_STEP;
			stop_ff <= RST_INPUT_STOP;
			filt_ff <= RST_FILTER_RES;
			ovf_ff <= RST_OV_FAULT; // [RQ19]
			ovw_ff <= RST_OV_WARN; // [RQ19]
			uvw_ff <= RST_UV_WARN; // [RQ20]
			uvf_ff <= RST_UV_FAULT; // [RQ20]
			okr_ff <= RST_OK_RISE; // [RQ21]
			okf_ff <= RST_OK_FALL; // [RQ21]
			ovresp_ff <= RST_OV_RESPONSE;
		end else if (wr) begin
			case (code)
				CODE_OPERATION: op_ff <= wd[7:0];
				CODE_SETPOINT: setpoint_ff <= sp_over ? RST_CEILING : wd; // [RQ23]
				CODE_UPPER_CLAMP: clamp_ff <= wd;
				CODE_MARGIN_HIGH: mhigh_ff <= wd;
				CODE_MARGIN_LOW: mlow_ff <= wd;
				CODE_SLEW_STEP: slew_ff <= wd;
				CODE_INPUT_STOP: stop_ff <= wd;
				CODE_FILTER_RES: filt_ff <= wd;
				CODE_OV_FAULT: ovf_ff <= wd;
				CODE_OV_RESPONSE: ovresp_ff <= wd[7:0];
				CODE_OV_WARN: ovw_ff <= wd;
				CODE_UV_WARN: uvw_ff <= wd;
				CODE_UV_FAULT: uvf_ff <= wd;
				CODE_OK_RISE: okr_ff <= wd; // thresholds stored only
				CODE_OK_FALL: okf_ff <= wd;
				default: op_ff <= op_ff;
			endcase
		end
	end

	// sticky status: a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ov_warn_ff <= 1'b0;
			uv_warn_ff <= 1'b0;
			max_warn_ff <= 1'b0;
			cml_ff <= 1'b0;
			ov_fault_ff <= 1'b0;
		end else begin
			ov_warn_ff <= (ov_warn_ff & ~clr) | ov_warn_evt; // [RQ10]
			uv_warn_ff <= (uv_warn_ff & ~clr) | uv_warn_evt; // [RQ11]
			max_warn_ff <= (max_warn_ff & ~clr) | max_evt; // [RQ23]
			cml_ff <= (cml_ff & ~clr) | max_evt | wr_err; // [RQ23]
			ov_fault_ff <= (ov_fault_ff & ~clr) | ov_comparator;
		end
	end

	// recalculation window after an overvoltage fault limit change in run state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt_ff <= 32'h0000_0000;
		end else if (wr && code == CODE_OV_FAULT && output_active) begin
			busy_cnt_ff <= RECALC_CYCLES; // [RQ6]
		end else if (busy) begin
			busy_cnt_ff <= busy_cnt_ff - 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_ff <= RST_SETPOINT;
			conv_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_err_ff <= 1'b0;
			rsp_data_ff <= 16'h0000;
		end else begin
			applied_ff <= nxt_applied; // [RQ15] [RQ16]
			conv_ff <= vin_measured > stop_ff; // [RQ1]
			rsp_valid_ff <= link.req_valid;
			rsp_err_ff <= (rd & ~rd_hit) | wr_err;
			rsp_data_ff <= rd ? rd_mux : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.rsp_valid = rsp_valid_ff;
	assign link.rsp_err = rsp_err_ff;
	assign link.rsp_rdata = rsp_data_ff;
	assign link.alert_n = ~any_status; // [RQ10] [RQ11]
	assign link.regulation_ok_signal = ~ov_comparator & ~uv_comparator; // [RQ17]
	assign conversion_enable = conv_ff;
	// gate acts without waiting a clock
	assign high_side_gate = pwm_high & ~ov_comparator; // [RQ8]
	assign low_side_gate_bit = ov_comparator; // [RQ8]
	assign fault_pin_n = ~(ov_fault_ff & ~crowbar_resp); // [RQ7]
	assign applied_setpoint = applied_ff;
endmodule // vreg_device

//--- rtl/vreg_host.sv
`timescale 1ns/1ps
module vreg_host import vreg_pkg::*; #(
	parameter int unsigned GUARD_CYCLES = RECALC_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command link
	cmd_link_if.host link
);
	typedef enum logic [1:0] {ST_IDLE, ST_GUARD, ST_REQ, ST_WAIT} host_state_t;
	host_state_t state_ff, nxt_state;
	logic [7:0] code_ff;
	logic [15:0] wdata_ff, rdata_ff;
	logic write_ff, nofilt_ff, err_ff, done_ff;
	logic [31:0] guard_ff;

	////////////////////////////////////////////////////////////////////////////
	wire apb_wr = psel & penable & pwrite;
	wire go = apb_wr & (paddr == APB_CTRL) & pwdata[CTRL_GO_BIT] & (state_ff == ST_IDLE);
	wire guarding = guard_ff != 32'h0000_0000;
	// raising the setpoint right after a limit change could trip a false fault
	wire needs_guard = (code_ff == CODE_SETPOINT) & write_ff & guarding; // [RQ5]
	wire [15:0] out_wdata = (write_ff && nofilt_ff && code_ff == CODE_FILTER_RES) ? 16'h0000 : wdata_ff; // [RQ2]
	wire busy = state_ff != ST_IDLE;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: nxt_state = go ? ST_GUARD : ST_IDLE;
			ST_GUARD: nxt_state = needs_guard ? ST_GUARD : ST_REQ;
			ST_REQ: nxt_state = ST_WAIT;
			ST_WAIT: nxt_state = link.rsp_valid ? ST_IDLE : ST_WAIT;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_ff <= 8'h00;
			wdata_ff <= 16'h0000;
			write_ff <= 1'b0;
			nofilt_ff <= 1'b0;
		end else if (apb_wr && !busy) begin
			if (paddr == APB_CODE) code_ff <= pwdata[7:0];
			if (paddr == APB_WDATA) wdata_ff <= pwdata[15:0];
			if (paddr == APB_CTRL) begin
				write_ff <= pwdata[CTRL_WRITE_BIT];
				nofilt_ff <= pwdata[CTRL_NOFILT_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_ff <= 32'h0000_0000;
			rdata_ff <= 16'h0000;
			err_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			if (state_ff == ST_REQ && write_ff && code_ff == CODE_OV_FAULT) begin
				guard_ff <= GUARD_CYCLES; // [RQ5]
			end else if (guarding) begin
				guard_ff <= guard_ff - 32'h0000_0001;
			end
			if (go) begin
				done_ff <= 1'b0;
			end else if (state_ff == ST_WAIT && link.rsp_valid) begin
				rdata_ff <= link.rsp_rdata;
				err_ff <= link.rsp_err;
				done_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.req_valid = state_ff == ST_REQ;
	assign link.req_write = write_ff;
	assign link.req_code = code_ff;
	assign link.req_wdata = out_wdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~((paddr == APB_CTRL) | (paddr == APB_CODE) | (paddr == APB_WDATA)
		| (paddr == APB_RDATA) | (paddr == APB_STATUS));
	assign prdata = (paddr == APB_CTRL) ? {29'h0, nofilt_ff, write_ff, 1'b0} :
		(paddr == APB_CODE) ? {24'h00_0000, code_ff} :
		(paddr == APB_WDATA) ? {16'h0000, wdata_ff} :
		(paddr == APB_RDATA) ? {16'h0000, rdata_ff} :
		(paddr == APB_STATUS) ? {26'h0, guarding, ~link.alert_n, link.regulation_ok_signal, err_ff, done_ff, busy} :
		32'h0000_0000;
endmodule // vreg_host

//--- rtl/vreg_pkg.sv
package vreg_pkg;
	// link command codes
	localparam logic [7:0] CODE_OPERATION = 8'h01;
	localparam logic [7:0] CODE_CLEAR_STATUS = 8'h03;
	localparam logic [7:0] CODE_FORMAT = 8'h20;
	localparam logic [7:0] CODE_SETPOINT = 8'h21;
	localparam logic [7:0] CODE_UPPER_CLAMP = 8'h24;
	localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
	localparam logic [7:0] CODE_MARGIN_LOW = 8'h26;
	localparam logic [7:0] CODE_SLEW_STEP = 8'h27;
	localparam logic [7:0] CODE_INPUT_STOP = 8'h36;
	localparam logic [7:0] CODE_OV_FAULT = 8'h40;
	localparam logic [7:0] CODE_OV_RESPONSE = 8'h41;
	localparam logic [7:0] CODE_OV_WARN = 8'h42;
	localparam logic [7:0] CODE_UV_WARN = 8'h43;
	localparam logic [7:0] CODE_UV_FAULT = 8'h44;
	localparam logic [7:0] CODE_OK_RISE = 8'h5e;
	localparam logic [7:0] CODE_OK_FALL = 8'h5f;
	localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
	localparam logic [7:0] CODE_STATUS_OUT = 8'h7a;
	localparam logic [7:0] CODE_STATUS_LOGIC = 8'h7e;
	localparam logic [7:0] CODE_CEILING = 8'ha5;
	localparam logic [7:0] CODE_COMMON = 8'hef;
	localparam logic [7:0] CODE_FILTER_RES = 8'hf7;
	// reset values
	localparam logic [7:0] RST_FORMAT = 8'h14;
	localparam logic [15:0] RST_SETPOINT = 16'h1000;
	localparam logic [15:0] RST_UPPER_CLAMP = 16'h5800;
	localparam logic [15:0] RST_MARGIN_HIGH = 16'h10cd;
	localparam logic [15:0] RST_MARGIN_LOW = 16'h0f33;
	localparam logic [15:0] RST_OV_FAULT = 16'h119a;
	localparam logic [15:0] RST_OV_WARN = 16'h1133;
	localparam logic [15:0] RST_UV_WARN = 16'h0ecd;
	localparam logic [15:0] RST_UV_FAULT = 16'h0e66;
	localparam logic [15:0] RST_OK_RISE = 16'h0ee1;
	localparam logic [15:0] RST_OK_FALL = 16'h0eb8;
	localparam logic [15:0] RST_CEILING = 16'h5800;
	localparam logic [15:0] RST_INPUT_STOP = 16'h0000;
	localparam logic [15:0] RST_FILTER_RES = 16'h0000;
	localparam logic [15:0] RST_SLEW_STEP = 16'h0001;
	localparam logic [7:0] RST_OV_RESPONSE = 8'h80;
	// field layouts
	localparam logic [7:0] OV_RESP_CROWBAR = 8'h80;
	localparam logic [7:0] OV_RESP_NONE = 8'h00;
	localparam int OP_MARGIN_LSB = 4;
	localparam logic [1:0] OP_NOMINAL = 2'b00;
	localparam logic [1:0] OP_MARGIN_LOW = 2'b01;
	localparam logic [1:0] OP_MARGIN_HIGH = 2'b10;
	localparam int SO_OV_WARN_BIT = 6;
	localparam int SO_UV_WARN_BIT = 5;
	localparam int SO_MAX_WARN_BIT = 3;
	localparam int SW_OUT_BIT = 15;
	localparam int SW_LOGIC_BIT = 1;
	localparam int SW_OTHER_BIT = 0;
	localparam int SL_INVALID_BIT = 6;
	localparam int CM_IDLE_A_BIT = 5;
	localparam int CM_IDLE_B_BIT = 6;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int RECALC_TIME_MS = 10;
	localparam int RECALC_CYC = RECALC_TIME_MS * CLK_MHZ * 1000;
	// host apb map
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_CODE = 8'h04;
	localparam logic [7:0] APB_WDATA = 8'h08;
	localparam logic [7:0] APB_RDATA = 8'h0c;
	localparam logic [7:0] APB_STATUS = 8'h10;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int CTRL_NOFILT_BIT = 2;
endpackage
